// [hw/pcs_top.sv]
// How it works
// - a one in a pull-up disable bit switches off the pull-ups of that pin group.
// - pins usable as general I/O are not governed by this register.
// - bit 15 of pull-up disable and bits 15..10 of clock-out select read zero, ignore writes.
// - pull-up disable bit 14 governs the pull-up of the pwm fault input three.
// - pull-up disable bit 13 governs the pull-up of the can receive pin.
// - select bit 9 gives port_b pin 7 address bit 23, or the master oscillator clock.
// - select bit 8 gives port_b pin 6 address bit 22, or the secondary system clock.
// - select bit 7 gives port_b pin 5 address bit 21, or the system clock.
// - select bit 6 gives port_b pin 4 address bit 20, or the prescaler reference clock.
// - clock_out_disable zero drives the selected clock, one tri-states the pin.
// - the five-bit clock_out_select chooses the clock; code 0 is the system clock.
// - code 7 is the oscillator output and code 8 the clock generator output.
`timescale 1ns/10ps
module pcs_top (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic [31:0]                  hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    input  wire pcs_pkg::pcs_clocks_type clocks,
    input  wire pcs_pkg::pcs_addr_type   addr_hi,
    output logic [14:0]                  pullup_off,
    output logic [3:0]                   port_b_alt_out,
    output logic                         clock_out_pin_o,
    output logic                         clock_out_pin_oe_n
);
    typedef struct packed {
        pcs_pkg::pcs_addr_phase_type ap;
        logic [15:0]                 pud;
        logic [15:0]                 cks;
        logic [31:0]                 rdata;
        logic [3:0]                  alt;
        logic                        oe_n;
        logic [14:0]                 pins_off;
        logic                        clock_out_pad;
    } pcs_state_type;

    pcs_state_type s_q;
    pcs_state_type s_d;
    logic          mux_q;
    logic          take;

    // every transfer is zero wait state, so the slave is always ready
    assign take = hsel && hready && (htrans == pcs_pkg::HTRANS_NONSEQ);

    always_comb begin
        s_d = s_q;
        s_d.ap.sel = take;
        if (take) begin
            s_d.ap.write = hwrite;
            s_d.ap.addr  = haddr[11:0];
        end
        // data phase write; reserved bits masked off
        if (s_q.ap.sel && s_q.ap.write) begin
            if (s_q.ap.addr == pcs_pkg::PULLUP_DISABLE_ADDR) begin
                s_d.pud = hwdata[15:0] & pcs_pkg::PUD_IMPL_MASK;
            end else if (s_q.ap.addr == pcs_pkg::CLOCK_OUT_PIN_SELECT_ADDR) begin
                s_d.cks = hwdata[15:0] & pcs_pkg::CKS_IMPL_MASK;
            end
        end
        // read data registered in the address phase, unmapped reads zero
        s_d.rdata = 32'h0000_0000;
        if (take && !hwrite) begin
            if (haddr[11:0] == pcs_pkg::PULLUP_DISABLE_ADDR) begin
                s_d.rdata = {16'h0000, s_d.pud};
            end else if (haddr[11:0] == pcs_pkg::CLOCK_OUT_PIN_SELECT_ADDR) begin
                s_d.rdata = {16'h0000, s_d.cks};
            end
        end
        // alternate outputs on port_b pins 7..4
        s_d.alt[3] = s_q.cks[pcs_pkg::CKS_ALT23] ? clocks.master_oscillator_clock
                                                 : addr_hi.addr_hi[3];
        s_d.alt[2] = s_q.cks[pcs_pkg::CKS_ALT22] ? clocks.secondary_system_clock
                                                 : addr_hi.addr_hi[2];
        s_d.alt[1] = s_q.cks[pcs_pkg::CKS_ALT21] ? clocks.system_clock
                                                 : addr_hi.addr_hi[1];
        s_d.alt[0] = s_q.cks[pcs_pkg::CKS_ALT20] ? clocks.prescaler_reference_clock
                                                 : addr_hi.addr_hi[0];
        s_d.oe_n = s_q.cks[pcs_pkg::CKS_DIS];
        // only non-gpio groups live here; gpio pull-ups stay with port logic
        s_d.pins_off = s_q.pud[14:0];
        s_d.clock_out_pad     = mux_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // a read whose address phase falls in a write's data phase sees the written value,
    // since rdata is built from s_d
    pcs_clk_mux u_mux (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sel     (s_q.cks[pcs_pkg::CKS_SEL_W-1:0]),
        .clocks  (clocks),
        .mux_q   (mux_q)
    );

    assign pullup_off         = s_q.pins_off;
    assign clock_out_pin_o    = s_q.clock_out_pad;
    assign hrdata             = s_q.rdata;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign port_b_alt_out     = s_q.alt;
    assign clock_out_pin_oe_n = s_q.oe_n;

    // assertions
    property p_pud_write;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.ap.sel && s_q.ap.write && s_q.ap.addr == pcs_pkg::PULLUP_DISABLE_ADDR)
            |=> (s_q.pud == ($past(hwdata[15:0]) & 16'h7FFF)) ##1 (pullup_off == $past(s_q.pud[14:0]));
    endproperty
    a_pud_write: assert property (p_pud_write) else $error("pull-up write lost");

    property p_reserved_zero;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.pud[15] == 1'b0) && (s_q.cks[15:10] == 6'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_bit14;
        @(posedge hclk) disable iff (!hresetn)
        s_q.pud[pcs_pkg::PUD_PWM_FAULT] |=> pullup_off[14];
    endproperty
    a_bit14: assert property (p_bit14) else $error("fault pull-up not off");

    property p_bit13;
        @(posedge hclk) disable iff (!hresetn)
        s_q.pud[pcs_pkg::PUD_CAN_RX] |=> pullup_off[13];
    endproperty
    a_bit13: assert property (p_bit13) else $error("can pull-up not off");

    property p_alt23;
        @(posedge hclk) disable iff (!hresetn)
        hresetn |=> port_b_alt_out[3] == ($past(s_q.cks[9])
            ? $past(clocks.master_oscillator_clock) : $past(addr_hi.addr_hi[3]));
    endproperty
    a_alt23: assert property (p_alt23) else $error("pin 7 alt wrong");

    property p_alt22;
        @(posedge hclk) disable iff (!hresetn)
        hresetn |=> port_b_alt_out[2] == ($past(s_q.cks[8])
            ? $past(clocks.secondary_system_clock) : $past(addr_hi.addr_hi[2]));
    endproperty
    a_alt22: assert property (p_alt22) else $error("pin 6 alt wrong");

    property p_alt21;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.cks[7] && clocks.system_clock) |=> port_b_alt_out[1];
    endproperty
    a_alt21: assert property (p_alt21) else $error("pin 5 alt wrong");

    property p_alt20;
        @(posedge hclk) disable iff (!hresetn)
        (!s_q.cks[6] && !addr_hi.addr_hi[0]) |=> !port_b_alt_out[0];
    endproperty
    a_alt20: assert property (p_alt20) else $error("pin 4 alt wrong");

    property p_disable;
        @(posedge hclk) disable iff (!hresetn)
        $rose(s_q.cks[5]) |=> clock_out_pin_oe_n;
    endproperty
    a_disable: assert property (p_disable) else $error("clock-out not tri-stated");

    property p_sel_sys;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.cks[4:0] == 5'h00 && clocks.system_clock) [*2] |=> ##1 clock_out_pin_o;
    endproperty
    a_sel_sys: assert property (p_sel_sys) else $error("system clock not out");

    property p_sel_osc;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.cks[4:0] == 5'h07 && clocks.oscillator_output) |=> ##1 clock_out_pin_o;
    endproperty
    a_sel_osc: assert property (p_sel_osc) else $error("oscillator not out");

    property p_sel_resv;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.cks[4:0] > 5'h0D) [*2] |=> !clock_out_pin_o;
    endproperty
    a_sel_resv: assert property (p_sel_resv) else $error("reserved code not low");

    property p_readback;
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr[11:0] == pcs_pkg::CLOCK_OUT_PIN_SELECT_ADDR && !(s_q.ap.sel && s_q.ap.write))
            |=> hrdata == {16'h0000, $past(s_q.cks)};
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong");

    property p_cks_write;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.ap.sel && s_q.ap.write && s_q.ap.addr == pcs_pkg::CLOCK_OUT_PIN_SELECT_ADDR)
            |=> (s_q.cks == ($past(hwdata[15:0]) & pcs_pkg::CKS_IMPL_MASK));
    endproperty
    a_cks_write: assert property (p_cks_write) else $error("select write lost");

    property p_pud_hold;
        @(posedge hclk) disable iff (!hresetn)
        !(s_q.ap.sel && s_q.ap.write && s_q.ap.addr == pcs_pkg::PULLUP_DISABLE_ADDR)
            |=> $stable(s_q.pud);
    endproperty
    a_pud_hold: assert property (p_pud_hold) else $error("pull-up changed unwritten");

    property p_cks_hold;
        @(posedge hclk) disable iff (!hresetn)
        !(s_q.ap.sel && s_q.ap.write && s_q.ap.addr == pcs_pkg::CLOCK_OUT_PIN_SELECT_ADDR)
            |=> $stable(s_q.cks);
    endproperty
    a_cks_hold: assert property (p_cks_hold) else $error("select changed unwritten");

    property p_pullup_follow;
        @(posedge hclk) disable iff (!hresetn)
        hresetn |=> pullup_off == $past(s_q.pud[14:0]);
    endproperty
    a_pullup_follow: assert property (p_pullup_follow) else $error("pull-up pins wrong");

    property p_bit14_clear;
        @(posedge hclk) disable iff (!hresetn)
        !s_q.pud[pcs_pkg::PUD_PWM_FAULT] |=> !pullup_off[14];
    endproperty
    a_bit14_clear: assert property (p_bit14_clear) else $error("fault pull-up off");

    property p_bit13_clear;
        @(posedge hclk) disable iff (!hresetn)
        !s_q.pud[pcs_pkg::PUD_CAN_RX] |=> !pullup_off[13];
    endproperty
    a_bit13_clear: assert property (p_bit13_clear) else $error("can pull-up off");

    property p_oe_follow;
        @(posedge hclk) disable iff (!hresetn)
        hresetn |=> clock_out_pin_oe_n == $past(s_q.cks[pcs_pkg::CKS_DIS]);
    endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("clock-out enable wrong");

    property p_enable;
        @(posedge hclk) disable iff (!hresetn)
        $fell(s_q.cks[pcs_pkg::CKS_DIS]) |=> !clock_out_pin_oe_n;
    endproperty
    a_enable: assert property (p_enable) else $error("clock-out not driven");

    property p_sel_clkgen;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.cks[4:0] == pcs_pkg::SEL_CLKGEN && clocks.clock_generator_out) |=> ##1 clock_out_pin_o;
    endproperty
    a_sel_clkgen: assert property (p_sel_clkgen) else $error("generator not out");

    property p_sel_osc_low;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.cks[4:0] == pcs_pkg::SEL_OSC && !clocks.oscillator_output) |=> ##1 !clock_out_pin_o;
    endproperty
    a_sel_osc_low: assert property (p_sel_osc_low) else $error("oscillator low lost");

    property p_sel_sys_low;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.cks[4:0] == pcs_pkg::SEL_SYSTEM && !clocks.system_clock) |=> ##1 !clock_out_pin_o;
    endproperty
    a_sel_sys_low: assert property (p_sel_sys_low) else $error("system clock low lost");

    property p_sel_test;
        @(posedge hclk) disable iff (!hresetn)
        ((s_q.cks[4:0] inside {[pcs_pkg::SEL_TEST_LO:pcs_pkg::SEL_TEST_HI],
                               [pcs_pkg::SEL_TEST2_LO:pcs_pkg::SEL_TEST2_HI]})
            && clocks.test_clocks[s_q.cks[3:0]]) |=> ##1 clock_out_pin_o;
    endproperty
    a_sel_test: assert property (p_sel_test) else $error("test clock not out");

    property p_rdata_idle;
        @(posedge hclk) disable iff (!hresetn)
        !(take && !hwrite) |=> (hrdata == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");

    property p_rdata_upper;
        @(posedge hclk) disable iff (!hresetn)
        hrdata[31:16] == 16'h0000;
    endproperty
    a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");

    property p_readback_pud;
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr[11:0] == pcs_pkg::PULLUP_DISABLE_ADDR
            && !(s_q.ap.sel && s_q.ap.write)) |=> hrdata == {16'h0000, $past(s_q.pud)};
    endproperty
    a_readback_pud: assert property (p_readback_pud) else $error("pull-up readback wrong");

    property p_alt21_low;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.cks[pcs_pkg::CKS_ALT21] && !clocks.system_clock) |=> !port_b_alt_out[1];
    endproperty
    a_alt21_low: assert property (p_alt21_low) else $error("pin 5 clock low lost");

    property p_alt21_addr;
        @(posedge hclk) disable iff (!hresetn)
        (hresetn && !s_q.cks[pcs_pkg::CKS_ALT21])
            |=> port_b_alt_out[1] == $past(addr_hi.addr_hi[1]);
    endproperty
    a_alt21_addr: assert property (p_alt21_addr) else $error("pin 5 address wrong");

    property p_alt20_clk;
        @(posedge hclk) disable iff (!hresetn)
        (hresetn && s_q.cks[pcs_pkg::CKS_ALT20])
            |=> port_b_alt_out[0] == $past(clocks.prescaler_reference_clock);
    endproperty
    a_alt20_clk: assert property (p_alt20_clk) else $error("pin 4 clock wrong");

    // checked only from the second reset edge on, the first may meet unset flops
    property p_reset_clear;
        @(posedge hclk)
        (!hresetn && !$past(hresetn)) |-> (s_q.pud == pcs_pkg::PUD_RESET
            && s_q.cks == pcs_pkg::CKS_RESET && pullup_off == 15'h0000 && !clock_out_pin_oe_n);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

    c_pud_write: cover property (@(posedge hclk) s_q.ap.sel && s_q.ap.write
                                 && s_q.ap.addr == pcs_pkg::PULLUP_DISABLE_ADDR);
    c_clk_off:   cover property (@(posedge hclk) clock_out_pin_oe_n);
    c_osc_sel:   cover property (@(posedge hclk) s_q.cks[4:0] == 5'h07);
    c_test_code: cover property (@(posedge hclk) s_q.cks[4:0] == pcs_pkg::SEL_TEST2_HI);
    c_resv_code: cover property (@(posedge hclk) s_q.cks[4:0] > pcs_pkg::SEL_TEST2_HI);
endmodule

// [hw/pcs_pkg.sv]
package pcs_pkg;
    // register map, byte addresses on the 32-bit bus
    localparam logic [11:0] PULLUP_DISABLE_ADDR = 12'h008;
    localparam logic [11:0] CLOCK_OUT_PIN_SELECT_ADDR  = 12'h00C;
    localparam int          REG_W               = 16;

    // pull-up disable register: implemented bits
    localparam logic [15:0] PUD_IMPL_MASK = 16'h7FFF;
    localparam logic [15:0] PUD_RESET     = 16'h0000;
    localparam int          PUD_PWM_FAULT = 14;
    localparam int          PUD_CAN_RX    = 13;
    localparam int          PUD_EXTERNAL_MEMORY_MODE_PIN  = 12;

    // clock-out and alternate function register
    localparam logic [15:0] CKS_IMPL_MASK = 16'h03FF;
    localparam logic [15:0] CKS_RESET     = 16'h0000;
    localparam int          CKS_ALT23     = 9;
    localparam int          CKS_ALT22     = 8;
    localparam int          CKS_ALT21     = 7;
    localparam int          CKS_ALT20     = 6;
    localparam int          CKS_DIS       = 5;
    localparam int          CKS_SEL_LSB   = 0;
    localparam int          CKS_SEL_W     = 5;

    // clock-out select codes
    localparam logic [4:0] SEL_SYSTEM     = 5'h00;
    localparam logic [4:0] SEL_TEST_LO    = 5'h01;
    localparam logic [4:0] SEL_TEST_HI    = 5'h06;
    localparam logic [4:0] SEL_OSC        = 5'h07;
    localparam logic [4:0] SEL_CLKGEN     = 5'h08;
    localparam logic [4:0] SEL_TEST2_LO   = 5'h09;
    localparam logic [4:0] SEL_TEST2_HI   = 5'h0D;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [11:0] addr;
    } pcs_addr_phase_type;

    // internal clocks the pin can show (taken as synchronous levels)
    typedef struct packed {
        logic system_clock;
        logic secondary_system_clock;
        logic master_oscillator_clock;
        logic prescaler_reference_clock;
        logic oscillator_output;
        logic clock_generator_out;
        logic [REG_W-1:0] test_clocks;
    } pcs_clocks_type;

    typedef struct packed {
        logic [3:0] addr_hi;
    } pcs_addr_type;
endpackage

// [hw/pcs_clk_mux.sv]
`timescale 1ns/10ps
// clock-out selector; registered so the pin comes from a flop
module pcs_clk_mux (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic [4:0]           sel,
    input  wire pcs_pkg::pcs_clocks_type clocks,
    output logic                      mux_q
);
    logic mux_d;

    always_comb begin
        mux_d = 1'b0;
        if (sel == pcs_pkg::SEL_SYSTEM) begin
            mux_d = clocks.system_clock;
        end else if (sel == pcs_pkg::SEL_OSC) begin
            mux_d = clocks.oscillator_output;
        end else if (sel == pcs_pkg::SEL_CLKGEN) begin
            mux_d = clocks.clock_generator_out;
        end else if (sel <= pcs_pkg::SEL_TEST2_HI) begin
            mux_d = clocks.test_clocks[sel[3:0]];
        end else begin
            mux_d = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mux_q <= 1'b0;
        end else begin
            mux_q <= mux_d;
        end
    end
endmodule

// [dv/pcs_tb_top.sv]
`timescale 1ns/10ps
module pullup_and_clockout_select_tb_top;
    logic                    hclk;
    logic                    hresetn;
    logic                    hsel;
    logic [31:0]             haddr;
    logic [1:0]              htrans;
    logic                    hwrite;
    logic [2:0]              hsize;
    logic [31:0]             hwdata;
    logic [31:0]             hrdata;
    logic                    hreadyout;
    logic                    hresp;
    pcs_pkg::pcs_clocks_type clocks;
    pcs_pkg::pcs_addr_type   addr_hi;
    logic [14:0]             pullup_off;
    logic [3:0]              port_b_alt_out;
    logic                    clock_out_pin_o;
    logic                    clock_out_pin_oe_n;
    int                      mismatches;
    int                      checks_done;
    int                      cycles;
    int                      i;
    int                      k;
    logic [31:0]             d;
    logic [31:0]             r;
    logic [31:0]             rnd;

    pcs_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .clocks(clocks), .addr_hi(addr_hi), .pullup_off(pullup_off),
        .port_b_alt_out(port_b_alt_out), .clock_out_pin_o(clock_out_pin_o),
        .clock_out_pin_oe_n(clock_out_pin_oe_n));

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // the run is about 630 cycles; this ceiling only catches a hung wait
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("ERROR %0t: timeout", $time);
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one single transfer; hready is waited on, no latency assumed
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= pcs_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        chk(hresp, 1'b0, "hresp");
    endtask

    task automatic new_inputs();
        rnd = $urandom;
        clocks <= rnd[21:0];
        rnd = $urandom;
        addr_hi <= rnd[3:0];
        repeat (4) @(posedge hclk);
    endtask

    function automatic logic exp_clk(input logic [4:0] s, input pcs_pkg::pcs_clocks_type c);
        if (s == pcs_pkg::SEL_SYSTEM) return c.system_clock;
        if (s == pcs_pkg::SEL_OSC) return c.oscillator_output;
        if (s == pcs_pkg::SEL_CLKGEN) return c.clock_generator_out;
        if (s <= pcs_pkg::SEL_TEST2_HI) return c.test_clocks[s[3:0]];
        return 1'b0;
    endfunction

    function automatic logic [3:0] exp_alt(input logic [31:0] v, input pcs_pkg::pcs_clocks_type c,
                                           input logic [3:0] a);
        return {v[9] ? c.master_oscillator_clock : a[3], v[8] ? c.secondary_system_clock : a[2],
                v[7] ? c.system_clock : a[1], v[6] ? c.prescaler_reference_clock : a[0]};
    endfunction

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = pcs_pkg::HSIZE_WORD;
        hwdata = 32'h0;
        clocks = '0;
        addr_hi = '0;
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        void'($urandom(35));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, pcs_pkg::PULLUP_DISABLE_ADDR, 32'h0, r);
        chk(r, 32'h0, "pud reset");
        ahb(1'b0, pcs_pkg::CLOCK_OUT_PIN_SELECT_ADDR, 32'h0, r);
        chk(r, 32'h0, "cks reset");
        chk({pullup_off, clock_out_pin_oe_n}, 16'h0, "pins reset");
        $display("test reset done");
        for (i = 0; i < 24; i++) begin
            d = (i == 0) ? 32'hFFFFFFFF : $urandom;
            ahb(1'b1, pcs_pkg::PULLUP_DISABLE_ADDR, d, r);
            ahb(1'b0, pcs_pkg::PULLUP_DISABLE_ADDR, 32'h0, r);
            chk(r, d & 32'h7FFF, "pud read");
            chk(pullup_off, d[14:0], "pullup_off");
        end
        $display("test pullup disable done");
        for (i = 0; i < 24; i++) begin
            d = (i == 0) ? 32'hFFFFFFFF : $urandom;
            ahb(1'b1, pcs_pkg::CLOCK_OUT_PIN_SELECT_ADDR, d, r);
            ahb(1'b0, pcs_pkg::CLOCK_OUT_PIN_SELECT_ADDR, 32'h0, r);
            chk(r, d & 32'h3FF, "cks read");
            new_inputs();
            chk(port_b_alt_out, exp_alt(d, clocks, addr_hi), "alt out");
            chk(clock_out_pin_oe_n, d[5], "oe_n");
            if (!d[5]) chk(clock_out_pin_o, exp_clk(d[4:0], clocks), "clock_out_pin");
        end
        $display("test alternate function done");
        // two clock sets per code so a stuck output cannot match by luck
        for (i = 0; i < 32; i++) begin
            d = i;
            ahb(1'b1, pcs_pkg::CLOCK_OUT_PIN_SELECT_ADDR, d, r);
            for (k = 0; k < 2; k++) begin
                new_inputs();
                chk(clock_out_pin_o, exp_clk(d[4:0], clocks), "code");
            end
        end
        $display("test select codes done");
        ahb(1'b1, 32'h10, 32'hFFFF, r);
        ahb(1'b0, 32'h10, 32'h0, r);
        chk(r, 32'h0, "unmapped");
        ahb(1'b1, pcs_pkg::PULLUP_DISABLE_ADDR, 32'h5555, r);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, pcs_pkg::PULLUP_DISABLE_ADDR, 32'h0, r);
        chk(r, 32'h0, "pud after reset");
        chk(pullup_off, 15'h0, "pins after reset");
        $display("test unmapped and reset done");
        summarize();
    end
endmodule
